// [design/fhp_regs.vh]
// fhp_regs.vh: offsets, field positions, reset values and timing counts
// assumes a 125 MHz sys_clk and a plain strobe register port
`ifndef FHP_REGS_VH
`define FHP_REGS_VH

// ********************
// register offsets
// ********************
`define FHP_CMD_ADDR 4'h0
`define FHP_TARGET_ADDR 4'h1
`define FHP_SRT_ADDR 4'h2
`define FHP_ST0_ADDR 4'h3
`define FHP_PCN_ADDR 4'h4
`define FHP_STAT_ADDR 4'h5
`define FHP_IDC_ADDR 4'h6
`define FHP_IDH_ADDR 4'h7
`define FHP_IDR_ADDR 4'h8
`define FHP_IDN_ADDR 4'h9
`define FHP_ST1_ADDR 4'ha
`define FHP_FMT_ADDR 4'hb
`define FHP_FMTIDX_ADDR 4'hc
`define FHP_FMTDAT_ADDR 4'hd

// ********************
// command codes
// ********************
`define FHP_CMD_READ_ID 8'h0a
`define FHP_CMD_RECAL 8'h07
`define FHP_CMD_SEEK 8'h0f
`define FHP_CMD_SENSE_INT 8'h08
`define FHP_CMD_POWERDOWN 8'h10
`define FHP_CMD_WAKE 8'h11

// ********************
// status register zero fields and the status register one missing mark bit
// ********************
`define FHP_ST0_IC_HI 7
`define FHP_ST0_IC_LO 6
`define FHP_ST0_SE 5
`define FHP_ST0_EC 4
`define FHP_ST0_HEAD 2
`define FHP_ST1_MA 0
`define FHP_IC_NORMAL 2'h0
`define FHP_IC_ABNORMAL 2'h1
`define FHP_IC_POLL 2'h3

// ********************
// reset values and counts
// ********************
`define FHP_SRT_RESET 4'h0
`define FHP_RECAL_MAX_STEPS 8'h4f
`define FHP_STEP_PULSE_NS 2000
`define FHP_CLK_NS 8
`define FHP_STEP_PULSE_CYC ((`FHP_STEP_PULSE_NS + `FHP_CLK_NS - 1) / `FHP_CLK_NS)
`define FHP_SRT_UNIT_US 500
`define FHP_SRT_UNIT_CYC (`FHP_SRT_UNIT_US * 1000 / `FHP_CLK_NS)
`define FHP_FIRST_GAP_UNITS 5'h01

// ********************
// track format layout
// ********************
`define FHP_MFM_GAP4A 8'h50
`define FHP_MFM_GAP1 8'h32
`define FHP_MFM_GAP2 8'h16
`define FHP_MFM_SYNC 8'h0c
`define FHP_MFM_GAP_BYTE 8'h4e
`define FHP_MFM_IAM_PRE 8'hc2
`define FHP_MFM_ID_PRE 8'ha1
`define FHP_FM_GAP4A 8'h28
`define FHP_FM_GAP1 8'h1a
`define FHP_FM_GAP2 8'h0b
`define FHP_FM_SYNC 8'h06
`define FHP_FM_GAP_BYTE 8'hff
`define FHP_IAM_BYTE 8'hfc
`define FHP_ID_ADDRESS_MARK_BYTE 8'hfe
`define FHP_DAM_BYTE 8'hfb
`define FHP_DDAM_BYTE 8'hf8
`define FHP_SYNC_BYTE 8'h00

`endif

// [design/fhp_head_ctrl.v]
// fhp_head_ctrl.v: head positioning control commands of a floppy controller
// assumes a register master on sys_clk and drive pins from another domain
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`include "fhp_regs.vh"

module fhp_head_ctrl
(
	input wire sys_clk,
	input wire rst_n,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire track_zero_input_n,
	input wire index_pulse_input_n,
	input wire id_found,
	input wire [7:0] id_cyl,
	input wire [7:0] id_head,
	input wire [7:0] id_sec,
	input wire [7:0] id_size,
	output reg step_out,
	output reg dir_out,
	output reg controller_interrupt_output
);

localparam ST_IDLE = 3'h0;
localparam ST_PULSE = 3'h1;
localparam ST_WAIT = 3'h2;
localparam ST_RDID = 3'h3;
localparam ST_DONE = 3'h4;

// ********************
// input synchronisers
// ********************
reg [1:0] tz_sync_q;
reg [1:0] idx_sync_q;
reg idx_prev_q;
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		tz_sync_q <= 2'h0;
		idx_sync_q <= 2'h3;
		idx_prev_q <= 1'b1;
	end
	else
	begin
		tz_sync_q <= {tz_sync_q[0], track_zero_input_n};
		idx_sync_q <= {idx_sync_q[0], index_pulse_input_n};
		idx_prev_q <= idx_sync_q[1];
	end
end
wire at_track_zero = tz_sync_q[1];
wire index_edge = idx_prev_q & ~idx_sync_q[1];

// ********************
// track format byte lookup
// ********************
// field order: gap4a, sync, iam, gap1, sync, id_address_mark, gap2
function [15:0] fmt_field;
	input mfm;
	input [2:0] idx;
	begin
		case (idx)
		3'h0: fmt_field = mfm ? {`FHP_MFM_GAP4A, `FHP_MFM_GAP_BYTE}
			: {`FHP_FM_GAP4A, `FHP_FM_GAP_BYTE};
		3'h1: fmt_field = mfm ? {`FHP_MFM_SYNC, `FHP_SYNC_BYTE}
			: {`FHP_FM_SYNC, `FHP_SYNC_BYTE};
		3'h2: fmt_field = mfm ? {`FHP_MFM_IAM_PRE, `FHP_IAM_BYTE}
			: {8'h00, `FHP_IAM_BYTE};
		3'h3: fmt_field = mfm ? {`FHP_MFM_GAP1, `FHP_MFM_GAP_BYTE}
			: {`FHP_FM_GAP1, `FHP_FM_GAP_BYTE};
		3'h4: fmt_field = mfm ? {`FHP_MFM_SYNC, `FHP_SYNC_BYTE}
			: {`FHP_FM_SYNC, `FHP_SYNC_BYTE};
		3'h5: fmt_field = mfm ? {`FHP_MFM_ID_PRE, `FHP_ID_ADDRESS_MARK_BYTE}
			: {8'h00, `FHP_ID_ADDRESS_MARK_BYTE};
		3'h6: fmt_field = mfm ? {`FHP_MFM_GAP2, `FHP_MFM_GAP_BYTE}
			: {`FHP_FM_GAP2, `FHP_FM_GAP_BYTE};
		default: fmt_field = {8'h00, `FHP_DAM_BYTE};
		endcase
	end
endfunction

// ********************
// state
// ********************
reg [2:0] state_q;
reg [7:0] present_cylinder_count_q;
reg [7:0] target_cylinder_number_q;
reg [3:0] step_rate_setting_q;
reg recal_q;
reg [7:0] steps_q;
reg [23:0] timer_q;
reg first_gap_q;
reg seek_end_flag_q;
reg equipment_check_flag_q;
reg [1:0] interrupt_code_field_q;
reg missing_address_mark_flag_q;
reg int_pend_q;
reg drive_busy_q;
reg cmd_busy_q;
reg powered_down_q;
reg [1:0] index_count_q;
reg [7:0] id_cyl_q;
reg [7:0] id_head_q;
reg [7:0] id_sec_q;
reg [7:0] id_size_q;
reg fmt_mfm_q;
reg [2:0] fmt_idx_q;

wire cmd_wr = reg_wr && reg_addr == `FHP_CMD_ADDR;
wire start_ok = !powered_down_q && state_q == ST_IDLE;
wire [7:0] status_register_zero = {interrupt_code_field_q,
	seek_end_flag_q, equipment_check_flag_q, 1'b0,
	1'b0, 2'h0};
wire [15:0] fmt_word = fmt_field(fmt_mfm_q, fmt_idx_q);
// interval grows with smaller setting code, 16 units at code 0
wire [4:0] srt_units = 5'h10 - {1'b0, step_rate_setting_q};
localparam [23:0] SRT_UNIT_CYC = `FHP_SRT_UNIT_CYC;
localparam [23:0] STEP_PULSE_CYC = `FHP_STEP_PULSE_CYC;
wire [4:0] gap_units = first_gap_q ? `FHP_FIRST_GAP_UNITS : srt_units;
wire [23:0] step_gap_cyc = {19'h0, gap_units} * SRT_UNIT_CYC;

// ********************
// command engine
// ********************
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		state_q <= ST_IDLE;
		present_cylinder_count_q <= 8'h00;
		target_cylinder_number_q <= 8'h00;
		step_rate_setting_q <= `FHP_SRT_RESET;
		recal_q <= 1'b0;
		steps_q <= 8'h00;
		timer_q <= 24'h0;
		first_gap_q <= 1'b0;
		seek_end_flag_q <= 1'b0;
		equipment_check_flag_q <= 1'b0;
		interrupt_code_field_q <= `FHP_IC_NORMAL;
		missing_address_mark_flag_q <= 1'b0;
		int_pend_q <= 1'b0;
		drive_busy_q <= 1'b0;
		cmd_busy_q <= 1'b0;
		powered_down_q <= 1'b0;
		index_count_q <= 2'h0;
		id_cyl_q <= 8'h00;
		id_head_q <= 8'h00;
		id_sec_q <= 8'h00;
		id_size_q <= 8'h00;
		fmt_mfm_q <= 1'b1;
		fmt_idx_q <= 3'h0;
		step_out <= 1'b0;
		dir_out <= 1'b0;
		controller_interrupt_output <= 1'b0;
	end
	else
	begin
		cmd_busy_q <= 1'b0;
		if (reg_wr && reg_addr == `FHP_TARGET_ADDR)
			target_cylinder_number_q <= reg_wdata;
		if (reg_wr && reg_addr == `FHP_SRT_ADDR)
			step_rate_setting_q <= reg_wdata[3:0];
		if (reg_wr && reg_addr == `FHP_FMT_ADDR)
			fmt_mfm_q <= reg_wdata[0];
		if (reg_wr && reg_addr == `FHP_FMTIDX_ADDR)
			fmt_idx_q <= reg_wdata[2:0];
		if (cmd_wr && reg_wdata == `FHP_CMD_POWERDOWN)
			powered_down_q <= 1'b1;
		if (cmd_wr && reg_wdata == `FHP_CMD_WAKE && powered_down_q)
		begin
			powered_down_q <= 1'b0;
			present_cylinder_count_q <= 8'h00;
			seek_end_flag_q <= 1'b0;
			equipment_check_flag_q <= 1'b0;
			interrupt_code_field_q <= `FHP_IC_NORMAL;
			missing_address_mark_flag_q <= 1'b0;
		end
		if (cmd_wr && reg_wdata == `FHP_CMD_SENSE_INT && !powered_down_q)
		begin
			int_pend_q <= 1'b0;
			drive_busy_q <= 1'b0;
		end
		case (state_q)
		ST_IDLE:
		begin
			step_out <= 1'b0;
			if (cmd_wr && start_ok)
			begin
				cmd_busy_q <= 1'b1;
				if (reg_wdata == `FHP_CMD_RECAL)
				begin
					present_cylinder_count_q <= 8'h00;
					dir_out <= 1'b0;
					recal_q <= 1'b1;
					steps_q <= 8'h00;
					seek_end_flag_q <= 1'b0;
					equipment_check_flag_q <= 1'b0;
					interrupt_code_field_q <= `FHP_IC_NORMAL;
					drive_busy_q <= 1'b1;
					first_gap_q <= 1'b1;
					timer_q <= 24'h0;
					state_q <= ST_WAIT;
				end
				else if (reg_wdata == `FHP_CMD_SEEK)
				begin
					dir_out <= present_cylinder_count_q <
						target_cylinder_number_q;
					recal_q <= 1'b0;
					seek_end_flag_q <= 1'b0;
					equipment_check_flag_q <= 1'b0;
					interrupt_code_field_q <= `FHP_IC_NORMAL;
					drive_busy_q <= 1'b1;
					first_gap_q <= 1'b1;
					timer_q <= 24'h0;
					state_q <= ST_WAIT;
				end
				else if (reg_wdata == `FHP_CMD_READ_ID)
				begin
					index_count_q <= 2'h0;
					seek_end_flag_q <= 1'b0;
					equipment_check_flag_q <= 1'b0;
					missing_address_mark_flag_q <= 1'b0;
					interrupt_code_field_q <= `FHP_IC_NORMAL;
					state_q <= ST_RDID;
				end
			end
		end
		ST_WAIT:
		begin
			// termination is checked before each pulse
			if (recal_q && at_track_zero)
			begin
				seek_end_flag_q <= 1'b1;
				state_q <= ST_DONE;
			end
			else if (recal_q && steps_q == `FHP_RECAL_MAX_STEPS)
			begin
				seek_end_flag_q <= 1'b1;
				equipment_check_flag_q <= 1'b1;
				interrupt_code_field_q <= `FHP_IC_ABNORMAL;
				state_q <= ST_DONE;
			end
			else if (!recal_q &&
				present_cylinder_count_q == target_cylinder_number_q)
			begin
				seek_end_flag_q <= 1'b1;
				state_q <= ST_DONE;
			end
			else if (timer_q == 24'h0)
			begin
				step_out <= 1'b1;
				timer_q <= STEP_PULSE_CYC;
				state_q <= ST_PULSE;
			end
			else
				timer_q <= timer_q - 24'h1;
		end
		ST_PULSE:
		begin
			if (timer_q == 24'h1)
			begin
				step_out <= 1'b0;
				steps_q <= steps_q + 8'h01;
				if (!recal_q)
					present_cylinder_count_q <= dir_out
						? present_cylinder_count_q + 8'h01
						: present_cylinder_count_q - 8'h01;
				timer_q <= step_gap_cyc;
				first_gap_q <= 1'b0;
				state_q <= ST_WAIT;
			end
			else
				timer_q <= timer_q - 24'h1;
		end
		ST_RDID:
		begin
			if (id_found)
			begin
				id_cyl_q <= id_cyl;
				id_head_q <= id_head;
				id_sec_q <= id_sec;
				id_size_q <= id_size;
				state_q <= ST_DONE;
			end
			else if (index_edge)
			begin
				if (index_count_q == 2'h1)
				begin
					interrupt_code_field_q <= `FHP_IC_ABNORMAL;
					missing_address_mark_flag_q <= 1'b1;
					state_q <= ST_DONE;
				end
				index_count_q <= index_count_q + 2'h1;
			end
		end
		ST_DONE:
		begin
			// completion has no result bytes, only the interrupt
			int_pend_q <= 1'b1;
			state_q <= ST_IDLE;
		end
		default:
			state_q <= ST_IDLE;
		endcase
		controller_interrupt_output <= int_pend_q;
	end
end

// ********************
// register read port
// ********************
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
		reg_rdata <= 8'h00;
	else if (reg_rd)
	begin
		case (reg_addr)
		`FHP_TARGET_ADDR: reg_rdata <= target_cylinder_number_q;
		`FHP_SRT_ADDR: reg_rdata <= {4'h0, step_rate_setting_q};
		`FHP_ST0_ADDR: reg_rdata <= status_register_zero;
		`FHP_PCN_ADDR: reg_rdata <= present_cylinder_count_q;
		`FHP_STAT_ADDR: reg_rdata <= {3'h0, powered_down_q,
			int_pend_q, drive_busy_q,
			cmd_busy_q | (state_q == ST_RDID), 1'b0};
		`FHP_IDC_ADDR: reg_rdata <= id_cyl_q;
		`FHP_IDH_ADDR: reg_rdata <= id_head_q;
		`FHP_IDR_ADDR: reg_rdata <= id_sec_q;
		`FHP_IDN_ADDR: reg_rdata <= id_size_q;
		`FHP_ST1_ADDR: reg_rdata <= {7'h0, missing_address_mark_flag_q};
		`FHP_FMT_ADDR: reg_rdata <= {7'h0, fmt_mfm_q};
		`FHP_FMTIDX_ADDR: reg_rdata <= fmt_word[15:8];
		`FHP_FMTDAT_ADDR: reg_rdata <= fmt_word[7:0];
		default: reg_rdata <= 8'h00;
		endcase
	end
	else
		reg_rdata <= 8'h00;
end

endmodule

// [testbench/fhp_head_ctrl_monitor.sv]
// fhp_head_ctrl_monitor.sv: port assertions for the head control block
// assumes one sys_clk domain and async active-low rst_n
module fhp_head_ctrl_monitor (
	input wire sys_clk,
	input wire rst_n,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire step_out,
	input wire dir_out,
	input wire controller_interrupt_output
);
	logic [8:0] hi_cnt_q;
	wire sense_wr = reg_wr && reg_addr == 4'h0 && reg_wdata == 8'h08;
	wire irq = controller_interrupt_output;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hi_cnt_q <= 9'h000;
		else
			hi_cnt_q <= step_out ? hi_cnt_q + 9'h001 : 9'h000;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ****
	// checks
	// ****
	chk_step_width: assert property
		($fell(step_out) |-> hi_cnt_q == 9'h0fa)
		else $error("step pulse width wrong");
	chk_dir_held: assert property
		(step_out |-> $stable(dir_out))
		else $error("direction moved during a step");
	chk_irq_after_step: assert property
		($rose(irq) |-> !step_out)
		else $error("interrupt raised mid step");
	chk_rdata_idle: assert property
		(!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	chk_sense_clear: assert property
		(sense_wr && irq |-> ##2 !irq)
		else $error("interrupt not cleared by sense");
	chk_irq_cause: assert property
		($fell(irq) |-> $past(sense_wr, 2))
		else $error("interrupt dropped without sense");
	chk_reset_quiet: assert property
		(disable iff (1'b0) !rst_n |-> !step_out && !dir_out && !irq)
		else $error("outputs active in reset");
	chk_irq_no_step: assert property
		(irq |-> !step_out)
		else $error("stepping while completion pending");

	cover property ($rose(step_out));
	cover property ($rose(irq));
	cover property (sense_wr && irq);
endmodule

bind fhp_head_ctrl fhp_head_ctrl_monitor fhp_head_ctrl_monitor_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .step_out(step_out), .dir_out(dir_out),
	.controller_interrupt_output(controller_interrupt_output));

// [testbench/fhp_drive_model.sv]
// fhp_drive_model.sv: floppy drive stand-in on the far side of the block
// assumes step pulses from the block and id requests from the bench
module fhp_drive_model #(parameter int IDX_PER = 2000) (
	input wire sys_clk,
	input wire rst_n,
	input wire step_out,
	input wire dir_out,
	input wire id_go,
	output wire track_zero_input_n,
	output wire index_pulse_input_n,
	output wire id_found,
	output wire [7:0] id_cyl,
	output wire [7:0] id_head,
	output wire [7:0] id_sec,
	output wire [7:0] id_size
);
	logic [7:0] cyl_q;
	logic step_q;
	int idx_q;

	// ****
	// head and spindle
	// ****
	// id bus shows the inverse outside the strobe, never a stale copy
	assign id_found = id_go;
	assign id_cyl = id_go ? cyl_q : ~cyl_q;
	assign id_head = id_go ? 8'h00 : 8'hff;
	assign id_sec = id_go ? 8'h05 : 8'hfa;
	assign id_size = id_go ? 8'h02 : 8'hfd;
	assign track_zero_input_n = (cyl_q == 8'h00);
	// spindle period shortened so two index pulses fit a short run
	assign index_pulse_input_n = (idx_q >= 8);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cyl_q <= 8'h00;
			step_q <= 1'b0;
			idx_q <= 0;
		end
		else
		begin
			step_q <= step_out;
			idx_q <= (idx_q == IDX_PER - 1) ? 0 : idx_q + 1;
			if (step_out && !step_q)
				cyl_q <= dir_out ? cyl_q + 8'h01 : cyl_q - 8'h01;
		end
	end
endmodule

// [testbench/test_fhp_head_ctrl.sv]
// test_fhp_head_ctrl.sv: self-checking bench for the head control block
// assumes the drive model beside it and the bound port monitor
`include "fhp_regs.vh"
module test_fhp_head_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int IDX_PER = 2000;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic id_go = 1'b0;
	wire [7:0] reg_rdata, id_cyl, id_head, id_sec, id_size;
	wire step_out, dir_out, tz_n, idx_n, id_found, irq;
	int error_cnt = 0;
	int num_checks = 0;
	int steps = 0;

	always #4 sys_clk = ~sys_clk;
	always @(posedge step_out) steps++;

	fhp_head_ctrl fhp_head_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.track_zero_input_n(tz_n), .index_pulse_input_n(idx_n),
		.id_found(id_found), .id_cyl(id_cyl), .id_head(id_head),
		.id_sec(id_sec), .id_size(id_size), .step_out(step_out),
		.dir_out(dir_out), .controller_interrupt_output(irq));
	fhp_drive_model #(.IDX_PER(IDX_PER)) fhp_drive_model_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .step_out(step_out),
		.dir_out(dir_out), .id_go(id_go), .track_zero_input_n(tz_n),
		.index_pulse_input_n(idx_n), .id_found(id_found), .id_cyl(id_cyl),
		.id_head(id_head), .id_sec(id_sec), .id_size(id_size));

	// ****
	// shared tasks
	// ****
	task automatic complete_run();
	begin
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	end
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
	begin
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	end
	endtask

	// bounded wait: a missing interrupt ends the run at once
	task automatic wait_irq(input int n);
	begin
		for (int i = 0; i < n && irq !== 1'b1; i++)
			@(posedge sys_clk);
		#1 chk({7'h00, irq}, 8'h01);
		if (irq !== 1'b1)
			complete_run();
	end
	endtask

	task automatic sense();
	begin
		wr(`FHP_CMD_ADDR, `FHP_CMD_SENSE_INT);
		repeat (3) @(posedge sys_clk);
		#1 chk({7'h00, irq}, 8'h00);
	end
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
	begin
		rd(`FHP_ST0_ADDR, 8'h00);
		rd(`FHP_PCN_ADDR, 8'h00);
		rd(4'hf, 8'h00);
		$display("test reset done");
	end
	endtask

	task automatic t_recal(input logic [7:0] n);
	begin
		steps = 0;
		wr(`FHP_CMD_ADDR, `FHP_CMD_RECAL);
		wait_irq(400);
		chk(8'(steps), n);
		chk({7'h00, dir_out}, 8'h00);
		rd(`FHP_ST0_ADDR, 8'h20);
		rd(`FHP_PCN_ADDR, 8'h00);
		rd(`FHP_STAT_ADDR, 8'h0c);
		sense();
		rd(`FHP_STAT_ADDR, 8'h00);
		$display("test recalibrate done");
	end
	endtask

	task automatic t_seek(input logic [7:0] tgt, input logic d);
	begin
		steps = 0;
		wr(`FHP_TARGET_ADDR, tgt);
		wr(`FHP_CMD_ADDR, `FHP_CMD_SEEK);
		repeat (4) @(posedge sys_clk);
		chk({7'h00, dir_out}, {7'h00, d});
		rd(`FHP_STAT_ADDR, 8'h04);
		wait_irq(600);
		chk(8'(steps), 8'h01);
		rd(`FHP_ST0_ADDR, 8'h20);
		rd(`FHP_PCN_ADDR, tgt);
		sense();
		$display("test seek done");
	end
	endtask

	task automatic t_id();
	begin
		wr(`FHP_CMD_ADDR, `FHP_CMD_READ_ID);
		@(posedge sys_clk);
		id_go <= 1'b1;
		@(posedge sys_clk);
		id_go <= 1'b0;
		wait_irq(100);
		rd(`FHP_IDC_ADDR, 8'h01);
		rd(`FHP_IDH_ADDR, 8'h00);
		rd(`FHP_IDR_ADDR, 8'h05);
		rd(`FHP_IDN_ADDR, 8'h02);
		sense();
		$display("test read id done");
	end
	endtask

	task automatic t_miss();
	begin
		wr(`FHP_CMD_ADDR, `FHP_CMD_READ_ID);
		wait_irq(3 * IDX_PER);
		rd(`FHP_ST0_ADDR, 8'h40);
		rd(`FHP_ST1_ADDR, 8'h01);
		sense();
		$display("test missing mark done");
	end
	endtask

	task automatic t_fmt();
	begin
		wr(`FHP_FMT_ADDR, 8'h01);
		wr(`FHP_FMTIDX_ADDR, 8'h00);
		rd(`FHP_FMTIDX_ADDR, 8'h50);
		rd(`FHP_FMTDAT_ADDR, 8'h4e);
		wr(`FHP_FMTIDX_ADDR, 8'h05);
		rd(`FHP_FMTIDX_ADDR, 8'ha1);
		rd(`FHP_FMTDAT_ADDR, 8'hfe);
		wr(`FHP_FMTIDX_ADDR, 8'h06);
		rd(`FHP_FMTIDX_ADDR, 8'h16);
		wr(`FHP_FMT_ADDR, 8'h00);
		wr(`FHP_FMTIDX_ADDR, 8'h03);
		rd(`FHP_FMTIDX_ADDR, 8'h1a);
		rd(`FHP_FMTDAT_ADDR, 8'hff);
		wr(`FHP_FMTIDX_ADDR, 8'h02);
		rd(`FHP_FMTDAT_ADDR, 8'hfc);
		$display("test format fields done");
	end
	endtask

	task automatic t_power();
	begin
		wr(`FHP_CMD_ADDR, `FHP_CMD_POWERDOWN);
		rd(`FHP_STAT_ADDR, 8'h10);
		wr(`FHP_CMD_ADDR, `FHP_CMD_WAKE);
		rd(`FHP_PCN_ADDR, 8'h00);
		rd(`FHP_ST0_ADDR, 8'h00);
		chk({7'h00, irq}, 8'h00);
		$display("test power cycle done");
	end
	endtask

	initial
	begin
		rst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_fmt();
		t_recal(8'h00);
		t_seek(8'h01, 1'b1);
		t_id();
		t_seek(8'h00, 1'b0);
		t_miss();
		t_seek(8'h01, 1'b1);
		t_power();
		t_recal(8'h01);
		complete_run();
	end
endmodule
